// ---- src/rt_pkg.sv ----
// Constants, register map and field layout of the retirement tagging block
package rt_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam int UOP_ID_W = 4;
  localparam int NUM_UOPS = 16;
  localparam int TAG_W = 4;
  localparam int NUM_UP = 4;
  localparam int EXEC_TYPE_W = 4;
  localparam int FE_TYPE_W = 2;
  localparam int REP_CAUSE_W = 2;
  localparam int NUM_CNT = 5;

  // Byte offsets of the registers
  localparam logic [ADDR_W-1:0] OFS_UP0 = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_UP1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_UP2 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_UP3 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_DOWN = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_FE = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_TCP = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_REP = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_UNTAG = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_CNT_FE = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_CNT_EX = 6'h2C;
  localparam logic [ADDR_W-1:0] OFS_CNT_REP = 6'h30;
  localparam logic [ADDR_W-1:0] OFS_CNT_INS = 6'h34;
  localparam logic [ADDR_W-1:0] OFS_CNT_UOP = 6'h38;

  // Upstream and downstream event select fields
  localparam int TAG_EN_BIT = 4;
  localparam int TAG_VAL_LSB = 5;
  localparam int EV_MASK_LSB = 9;
  localparam int DN_COMMIT_LSB = 9;
  localparam int DN_CANCEL_LSB = 13;

  // Path mask bits shared by front-end, replay and untagged registers
  localparam int PATH_COMMIT_BIT = 0;
  localparam int PATH_CANCEL_BIT = 1;
  localparam int UNTAG_INS_BIT = 2;
  localparam int UNTAG_UOP_BIT = 3;
  localparam int SEL_LSB = 4;
  localparam int CTRL_CLR_BIT = 0;

  // Writable bits of each register; the rest read as zero
  localparam logic [DATA_W-1:0] UP_WMASK = 32'h01FF_FFF0;
  localparam logic [DATA_W-1:0] DOWN_WMASK = 32'h0001_FFF0;
  localparam logic [DATA_W-1:0] FE_WMASK = 32'h0000_00F3;
  localparam logic [DATA_W-1:0] TCP_WMASK = 32'h0000_FFFF;
  localparam logic [DATA_W-1:0] REP_WMASK = 32'h0000_00F3;
  localparam logic [DATA_W-1:0] UNTAG_WMASK = 32'h0000_000F;
  localparam logic [DATA_W-1:0] REG_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CNT_ONE = 32'h0000_0001;

  // Tag table entry layout
  localparam int ENT_FE = 0;
  localparam int ENT_EX_LSB = 1;
  localparam int ENT_REP = 5;
  localparam int ENT_UNTAG = 6;
  localparam int ENT_LAST = 7;
  localparam int ENT_W = 8;
  localparam logic [ENT_W-1:0] ENT_RST = 8'h00;

  // Counter slots
  localparam int CNT_FE = 0;
  localparam int CNT_EX = 1;
  localparam int CNT_REP = 2;
  localparam int CNT_INS = 3;
  localparam int CNT_UOP = 4;

  // Replay cause codes
  localparam logic [REP_CAUSE_W-1:0] CAUSE_MISS = 2'h0;
  localparam logic [REP_CAUSE_W-1:0] CAUSE_DEP = 2'h1;
  localparam logic [REP_CAUSE_W-1:0] CAUSE_RES = 2'h2;
  localparam logic [REP_CAUSE_W-1:0] CAUSE_MISPRED = 2'h3;

endpackage

// ---- src/rt_tag_store.sv ----
// Per micro-op tag table, indexed by micro-op identifier
`timescale 1ns/1ps
`default_nettype none
module rt_tag_store (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic alloc_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] alloc_id_in,
  input wire logic alloc_untag_in,
  input wire logic alloc_last_in,
  input wire logic cancel_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] cancel_id_in,
  input wire logic fe_set_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] fe_id_in,
  input wire logic [rt_pkg::TAG_W-1:0] ex_bits_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] ex_id_in,
  input wire logic rep_set_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] rep_id_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] rd_id_in,
  output logic [rt_pkg::ENT_W-1:0] rd_ent_out
);

  logic [rt_pkg::ENT_W-1:0] ent_q [rt_pkg::NUM_UOPS];

  function automatic logic id_hit(input logic v,
                                  input logic [rt_pkg::UOP_ID_W-1:0] id,
                                  input int idx);
    id_hit = v && (id == idx[rt_pkg::UOP_ID_W-1:0]);
  endfunction

  assign rd_ent_out = ent_q[rd_id_in];

  for (genvar i = 0; i < rt_pkg::NUM_UOPS; i++) begin : g_ent
    wire logic a_hit = id_hit(alloc_valid_in, alloc_id_in, i);
    wire logic c_hit = id_hit(cancel_valid_in, cancel_id_in, i) && !a_hit;
    wire logic [rt_pkg::ENT_W-1:0] base = a_hit ?
      {alloc_last_in, alloc_untag_in, 6'h00} :
      (c_hit ? rt_pkg::ENT_RST : ent_q[i]);
    // Sets only OR in, so repeated events leave one tag
    wire logic [rt_pkg::ENT_W-1:0] sets = {2'h0,
      id_hit(rep_set_in, rep_id_in, i),
      (id_hit(1'b1, ex_id_in, i) ? ex_bits_in : 4'h0),
      id_hit(fe_set_in, fe_id_in, i)};
    wire logic [rt_pkg::ENT_W-1:0] ent_d =
      (base[rt_pkg::ENT_UNTAG] || c_hit) ? base : (base | sets);
    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        ent_q[i] <= rt_pkg::ENT_RST;
      end else begin
        ent_q[i] <= ent_d;
      end
    end

    a_untag_clean: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ent_q[i][rt_pkg::ENT_UNTAG] |-> ent_q[i][5:0] == 6'h00)
      else $error("untaggable micro-op carries a tag");
    a_cancel_drops: assert property (@(posedge clock_in)
      disable iff (!nrst_in)
      c_hit |=> ent_q[i] == rt_pkg::ENT_RST)
      else $error("cancelled micro-op kept its tags");
    a_fe_sticky: assert property (@(posedge clock_in) disable iff (!nrst_in)
      ent_q[i][rt_pkg::ENT_FE] && !a_hit && !c_hit
      |=> ent_q[i][rt_pkg::ENT_FE])
      else $error("front-end tag lost before retirement");
  end

endmodule
`default_nettype wire

// ---- src/rt_counter_bank.sv ----
// Retirement event counters with software clear
`timescale 1ns/1ps
`default_nettype none
module rt_counter_bank (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire logic [rt_pkg::NUM_CNT-1:0] inc_in,
  output logic [rt_pkg::NUM_CNT-1:0][rt_pkg::DATA_W-1:0] cnt_out
);

  for (genvar i = 0; i < rt_pkg::NUM_CNT; i++) begin : g_cnt
    // A clear keeps an increment of the same cycle
    wire logic [rt_pkg::DATA_W-1:0] step =
      inc_in[i] ? rt_pkg::CNT_ONE : rt_pkg::REG_RST;
    wire logic [rt_pkg::DATA_W-1:0] cnt_d =
      clear_in ? step : cnt_out[i] + step;
    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        cnt_out[i] <= rt_pkg::REG_RST;
      end else begin
        cnt_out[i] <= cnt_d;
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/rt_top.sv ----
// Retirement event tagging and counting with Avalon-MM register access
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rt_top (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [rt_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [rt_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [rt_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic uop_alloc_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] uop_alloc_id_in,
  input wire logic uop_alloc_untaggable_in,
  input wire logic uop_alloc_last_in,
  input wire logic uop_cancel_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] uop_cancel_id_in,
  input wire logic fe_event_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] fe_event_id_in,
  input wire logic [rt_pkg::FE_TYPE_W-1:0] fe_event_type_in,
  input wire logic exec_event_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] exec_event_id_in,
  input wire logic [rt_pkg::EXEC_TYPE_W-1:0] exec_event_type_in,
  input wire logic replay_event_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] replay_event_id_in,
  input wire logic [rt_pkg::REP_CAUSE_W-1:0] replay_event_cause_in,
  input wire logic retire_valid_in,
  input wire logic [rt_pkg::UOP_ID_W-1:0] retire_id_in,
  input wire logic retire_bogus_in
);

  // Register file
  logic [rt_pkg::DATA_W-1:0] up_q [rt_pkg::NUM_UP];
  logic [rt_pkg::DATA_W-1:0] down_q;
  logic [rt_pkg::DATA_W-1:0] fe_q;
  logic [rt_pkg::DATA_W-1:0] tcp_q;
  logic [rt_pkg::DATA_W-1:0] rep_q;
  logic [rt_pkg::DATA_W-1:0] untag_q;
  logic wait_q;
  logic [rt_pkg::DATA_W-1:0] rdata_q;
  logic [rt_pkg::NUM_CNT-1:0][rt_pkg::DATA_W-1:0] cnt_w;

  function automatic logic [rt_pkg::DATA_W-1:0] merge(
      input logic [rt_pkg::DATA_W-1:0] old_v,
      input logic [rt_pkg::DATA_W-1:0] new_v,
      input logic [3:0] be,
      input logic [rt_pkg::DATA_W-1:0] wmask);
    logic [rt_pkg::DATA_W-1:0] lane;
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = ((old_v & ~lane) | (new_v & lane)) & wmask;
  endfunction

  // Committed or cancelled selection from a path mask pair
  function automatic logic path_ok(input logic [rt_pkg::DATA_W-1:0] r,
                                   input logic committed,
                                   input logic cancelled);
    path_ok = (committed && r[rt_pkg::PATH_COMMIT_BIT]) ||
              (cancelled && r[rt_pkg::PATH_CANCEL_BIT]);
  endfunction

  // Tag bits that one upstream select register applies
  function automatic logic [rt_pkg::TAG_W-1:0] up_tag(
      input logic [rt_pkg::DATA_W-1:0] r,
      input logic [rt_pkg::EXEC_TYPE_W-1:0] t);
    up_tag = (r[rt_pkg::TAG_EN_BIT] && r[rt_pkg::EV_MASK_LSB + int'(t)]) ?
             r[rt_pkg::TAG_VAL_LSB +: rt_pkg::TAG_W] : 4'h0;
  endfunction

  // Bus decode
  wire logic bus_req = avs_read_in || avs_write_in;
  wire logic wr_fire = avs_write_in && !wait_q;
  wire logic rd_take = avs_read_in && wait_q;
  wire logic wait_d = !(bus_req && wait_q);
  wire logic hit_down = wr_fire && (avs_address_in == rt_pkg::OFS_DOWN);
  wire logic hit_fe = wr_fire && (avs_address_in == rt_pkg::OFS_FE);
  wire logic hit_tcp = wr_fire && (avs_address_in == rt_pkg::OFS_TCP);
  wire logic hit_rep = wr_fire && (avs_address_in == rt_pkg::OFS_REP);
  wire logic hit_untag = wr_fire && (avs_address_in == rt_pkg::OFS_UNTAG);
  wire logic clr_cnt = wr_fire && (avs_address_in == rt_pkg::OFS_CTRL) &&
                       avs_byteenable_in[0] &&
                       avs_writedata_in[rt_pkg::CTRL_CLR_BIT];
  wire logic [rt_pkg::DATA_W-1:0] rd_mux =
    (avs_address_in == rt_pkg::OFS_UP0) ? up_q[0] :
    (avs_address_in == rt_pkg::OFS_UP1) ? up_q[1] :
    (avs_address_in == rt_pkg::OFS_UP2) ? up_q[2] :
    (avs_address_in == rt_pkg::OFS_UP3) ? up_q[3] :
    (avs_address_in == rt_pkg::OFS_DOWN) ? down_q :
    (avs_address_in == rt_pkg::OFS_FE) ? fe_q :
    (avs_address_in == rt_pkg::OFS_TCP) ? tcp_q :
    (avs_address_in == rt_pkg::OFS_REP) ? rep_q :
    (avs_address_in == rt_pkg::OFS_UNTAG) ? untag_q :
    (avs_address_in == rt_pkg::OFS_CNT_FE) ? cnt_w[rt_pkg::CNT_FE] :
    (avs_address_in == rt_pkg::OFS_CNT_EX) ? cnt_w[rt_pkg::CNT_EX] :
    (avs_address_in == rt_pkg::OFS_CNT_REP) ? cnt_w[rt_pkg::CNT_REP] :
    (avs_address_in == rt_pkg::OFS_CNT_INS) ? cnt_w[rt_pkg::CNT_INS] :
    (avs_address_in == rt_pkg::OFS_CNT_UOP) ? cnt_w[rt_pkg::CNT_UOP] :
    rt_pkg::REG_RST;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_q <= 1'b1;
      rdata_q <= rt_pkg::REG_RST;
    end else begin
      wait_q <= wait_d;
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;

  // Upstream select registers, one per generate slot
  for (genvar u = 0; u < rt_pkg::NUM_UP; u++) begin : g_up
    wire logic hit_up = wr_fire &&
      (avs_address_in == rt_pkg::OFS_UP0 + 6'(4 * u));
    always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
        up_q[u] <= rt_pkg::REG_RST;
      end else if (hit_up) begin
        up_q[u] <= merge(up_q[u], avs_writedata_in, avs_byteenable_in,
                         rt_pkg::UP_WMASK);
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      down_q <= rt_pkg::REG_RST;
      fe_q <= rt_pkg::REG_RST;
      tcp_q <= rt_pkg::REG_RST;
      rep_q <= rt_pkg::REG_RST;
      untag_q <= rt_pkg::REG_RST;
    end else begin
      if (hit_down) begin
        down_q <= merge(down_q, avs_writedata_in, avs_byteenable_in,
                        rt_pkg::DOWN_WMASK);
      end
      if (hit_fe) begin
        fe_q <= merge(fe_q, avs_writedata_in, avs_byteenable_in,
                      rt_pkg::FE_WMASK);
      end
      if (hit_tcp) begin
        tcp_q <= merge(tcp_q, avs_writedata_in, avs_byteenable_in,
                       rt_pkg::TCP_WMASK);
      end
      if (hit_rep) begin
        rep_q <= merge(rep_q, avs_writedata_in, avs_byteenable_in,
                       rt_pkg::REP_WMASK);
      end
      if (hit_untag) begin
        untag_q <= merge(untag_q, avs_writedata_in, avs_byteenable_in,
                         rt_pkg::UNTAG_WMASK);
      end
    end
  end

  // Tagging at event time
  // Decode events are picked by the front-end select field alone
  wire logic fe_set = fe_event_valid_in &&
    fe_q[rt_pkg::SEL_LSB + int'(fe_event_type_in)];
  wire logic [rt_pkg::TAG_W-1:0] ex_bits = !exec_event_valid_in ? 4'h0 :
    (up_tag(up_q[0], exec_event_type_in) |
     up_tag(up_q[1], exec_event_type_in) |
     up_tag(up_q[2], exec_event_type_in) |
     up_tag(up_q[3], exec_event_type_in));
  // Mispredicts share the replay tag through cause code three
  wire logic rep_set = replay_event_valid_in &&
    rep_q[rt_pkg::SEL_LSB + int'(replay_event_cause_in)];

  wire logic [rt_pkg::ENT_W-1:0] rd_ent;

  rt_tag_store u_store (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .alloc_valid_in(uop_alloc_valid_in),
    .alloc_id_in(uop_alloc_id_in),
    .alloc_untag_in(uop_alloc_untaggable_in),
    .alloc_last_in(uop_alloc_last_in),
    .cancel_valid_in(uop_cancel_valid_in),
    .cancel_id_in(uop_cancel_id_in),
    .fe_set_in(fe_set),
    .fe_id_in(fe_event_id_in),
    .ex_bits_in(ex_bits),
    .ex_id_in(exec_event_id_in),
    .rep_set_in(rep_set),
    .rep_id_in(replay_event_id_in),
    .rd_id_in(retire_id_in),
    .rd_ent_out(rd_ent)
  );

  // Counting at retirement; one bogus flag keeps the paths exclusive
  wire logic ret_commit = retire_valid_in && !retire_bogus_in;
  wire logic ret_cancel = retire_valid_in && retire_bogus_in;
  // Each detector reads only its own mechanism's field
  wire logic inc_fe = rd_ent[rt_pkg::ENT_FE] &&
    path_ok(fe_q, ret_commit, ret_cancel);
  // Downstream tag enable and tag value are never looked at
  wire logic [rt_pkg::TAG_W-1:0] dn_sel = ret_commit ?
    down_q[rt_pkg::DN_COMMIT_LSB +: rt_pkg::TAG_W] :
    down_q[rt_pkg::DN_CANCEL_LSB +: rt_pkg::TAG_W];
  wire logic inc_ex = retire_valid_in &&
    |(rd_ent[rt_pkg::ENT_EX_LSB +: rt_pkg::TAG_W] & dn_sel);
  wire logic inc_rep = rd_ent[rt_pkg::ENT_REP] &&
    path_ok(rep_q, ret_commit, ret_cancel);
  wire logic untag_path = path_ok(untag_q, ret_commit, ret_cancel);
  wire logic inc_uop = untag_path && untag_q[rt_pkg::UNTAG_UOP_BIT];
  wire logic inc_ins = untag_path && untag_q[rt_pkg::UNTAG_INS_BIT] &&
    rd_ent[rt_pkg::ENT_LAST];

  rt_counter_bank u_cnt (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .clear_in(clr_cnt),
    .inc_in({inc_uop, inc_ins, inc_rep, inc_ex, inc_fe}),
    .cnt_out(cnt_w)
  );

  // Checks
  sequence s_bus_req;
    bus_req && wait_q;
  endsequence

  sequence s_ack_pulse;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  a_bus_ack_once: assert property (@(posedge clock_in)
    disable iff (!nrst_in) s_bus_req |=> s_ack_pulse)
    else $error("bus request not acknowledged for exactly one cycle");

  a_path_exclusive: assert property (@(posedge clock_in)
    disable iff (!nrst_in) !(ret_commit && ret_cancel))
    else $error("micro-op classified on both paths");

  a_fe_count_once: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    ret_commit && rd_ent[rt_pkg::ENT_FE] &&
    fe_q[rt_pkg::PATH_COMMIT_BIT] && !clr_cnt
    |=> cnt_w[rt_pkg::CNT_FE] == $past(cnt_w[rt_pkg::CNT_FE]) + 32'h0000_0001)
    else $error("front-end tagged micro-op not counted once");

  a_ex_isolated: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    retire_valid_in && rd_ent[rt_pkg::ENT_EX_LSB +: rt_pkg::TAG_W] == 4'h0
    && !clr_cnt
    |=> cnt_w[rt_pkg::CNT_EX] == $past(cnt_w[rt_pkg::CNT_EX]))
    else $error("execution counter moved without an execution tag");

  a_ex_mask_count: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    ret_commit && !clr_cnt &&
    |(rd_ent[rt_pkg::ENT_EX_LSB +: rt_pkg::TAG_W] &
      down_q[rt_pkg::DN_COMMIT_LSB +: rt_pkg::TAG_W])
    |=> cnt_w[rt_pkg::CNT_EX] == $past(cnt_w[rt_pkg::CNT_EX]) + 32'h0000_0001)
    else $error("selected execution tag not counted by one");

  a_rep_count: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    ret_cancel && rd_ent[rt_pkg::ENT_REP] &&
    rep_q[rt_pkg::PATH_CANCEL_BIT] && !clr_cnt
    |=> cnt_w[rt_pkg::CNT_REP] == $past(cnt_w[rt_pkg::CNT_REP]) + 32'h0000_0001)
    else $error("replay tagged micro-op not counted");

  a_uop_untagged: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    ret_commit && untag_q[rt_pkg::PATH_COMMIT_BIT] &&
    untag_q[rt_pkg::UNTAG_UOP_BIT] && !clr_cnt
    |=> cnt_w[rt_pkg::CNT_UOP] == $past(cnt_w[rt_pkg::CNT_UOP]) + 32'h0000_0001)
    else $error("retired micro-op missed by untagged count");

  a_ex_tag_apply: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    exec_event_valid_in && up_q[0][rt_pkg::TAG_EN_BIT] &&
    up_q[0][rt_pkg::EV_MASK_LSB + int'(exec_event_type_in)]
    |-> (ex_bits & up_q[0][rt_pkg::TAG_VAL_LSB +: rt_pkg::TAG_W]) ==
        up_q[0][rt_pkg::TAG_VAL_LSB +: rt_pkg::TAG_W])
    else $error("upstream tag value not applied");

  a_down_ignores: assert property (@(posedge clock_in)
    disable iff (!nrst_in)
    ret_commit && !clr_cnt &&
    (rd_ent[rt_pkg::ENT_EX_LSB +: rt_pkg::TAG_W] &
     down_q[rt_pkg::DN_COMMIT_LSB +: rt_pkg::TAG_W]) == 4'h0
    |=> cnt_w[rt_pkg::CNT_EX] == $past(cnt_w[rt_pkg::CNT_EX]))
    else $error("downstream tag fields changed the execution count");

endmodule
`default_nettype wire

// ---- bench/retirement_event_tagging_bench.sv ----
// Self-checking bench for the retirement tagging block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", nm, exp, got); end end
module retirement_event_tagging_bench;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [5:0] addr = '0;
  logic rd = 1'b0, wr = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] be = 4'h0, id = 4'h0, arg = 4'h0;
  logic waitreq;
  logic [5:0] vld = '0;
  logic [31:0] q;
  int n_errors = 0, compares = 0;
  always #2.5 clock_in = ~clock_in;
  rt_top uut (.clock_in(clock_in), .nrst_in(nrst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .uop_alloc_valid_in(vld[0]), .uop_alloc_id_in(id),
    .uop_alloc_untaggable_in(arg[0]), .uop_alloc_last_in(arg[1]),
    .uop_cancel_valid_in(vld[5]), .uop_cancel_id_in(id),
    .fe_event_valid_in(vld[2]), .fe_event_id_in(id),
    .fe_event_type_in(arg[1:0]),
    .exec_event_valid_in(vld[1]), .exec_event_id_in(id),
    .exec_event_type_in(arg),
    .replay_event_valid_in(vld[3]), .replay_event_id_in(id),
    .replay_event_cause_in(arg[1:0]),
    .retire_valid_in(vld[4]), .retire_id_in(id),
    .retire_bogus_in(arg[0]));
  // One bus access; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clock_in);
    rd <= ~w; wr <= w; addr <= a; wdata <= d; be <= b;
    do @(posedge clock_in); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  // Kinds: 0 alloc, 1 exec, 2 front end, 3 replay, 4 retire, 5 cancel
  task automatic ev(input int k, input logic [3:0] i, input logic [3:0] x);
    @(posedge clock_in);
    vld <= 6'h01 << k; id <= i; arg <= x;
    @(posedge clock_in);
    vld <= '0;
  endtask
  task automatic cnt(input logic [5:0] a, input logic [31:0] e,
                     input string nm);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    `CHK(nm, e, q)
  endtask
  task automatic test_regs;
    cnt(rt_pkg::OFS_UP0, 32'h0000_0000, "up0 reset");
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0000, "ex reset");
    wreg(rt_pkg::OFS_UP1, 32'hFFFF_FFFF);
    cnt(rt_pkg::OFS_UP1, 32'h01FF_FFF0, "up1 mask");
    bus(1'b1, rt_pkg::OFS_UP1, 32'h0000_0000, 4'h1);
    cnt(rt_pkg::OFS_UP1, 32'h01FF_FF00, "up1 lane");
    wreg(6'h3C, 32'hFFFF_FFFF);
    cnt(6'h3C, 32'h0000_0000, "unmapped");
    wreg(rt_pkg::OFS_CNT_EX, 32'h0000_0055);
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0000, "ro counter");
    $display("test regs done");
  endtask
  task automatic test_exec;
    wreg(rt_pkg::OFS_UP0, 32'h0000_0830);
    wreg(rt_pkg::OFS_UP1, 32'h0000_1050);
    wreg(rt_pkg::OFS_DOWN, 32'h0000_07F0);
    wreg(rt_pkg::OFS_CTRL, 32'h0000_0001);
    ev(0, 4'h3, 4'h0); ev(1, 4'h3, 4'h2); ev(1, 4'h3, 4'h2); ev(4, 4'h3, 4'h0);
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0001, "ex once");
    ev(0, 4'h6, 4'h0); ev(1, 4'h6, 4'h2); ev(1, 4'h6, 4'h3); ev(4, 4'h6, 4'h0);
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0002, "ex combo");
    ev(0, 4'h4, 4'h0); ev(1, 4'h4, 4'h2); ev(5, 4'h4, 4'h0);
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0002, "ex cancel");
    ev(0, 4'h5, 4'h1); ev(1, 4'h5, 4'h2); ev(4, 4'h5, 4'h0);
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0002, "ex untaggable");
    ev(0, 4'h8, 4'h0); ev(1, 4'h8, 4'h2); ev(4, 4'h8, 4'h1);
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0002, "ex bogus");
    ev(0, 4'h7, 4'h0); ev(1, 4'h7, 4'h5); ev(4, 4'h7, 4'h0);
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0002, "ex unselected");
    cnt(rt_pkg::OFS_CNT_FE, 32'h0000_0000, "fe untouched");
    cnt(rt_pkg::OFS_CNT_REP, 32'h0000_0000, "rep untouched");
    $display("test exec done");
  endtask
  task automatic test_fe_rep;
    wreg(rt_pkg::OFS_FE, 32'h0000_00F1);
    wreg(rt_pkg::OFS_REP, 32'h0000_00F3);
    wreg(rt_pkg::OFS_CTRL, 32'h0000_0001);
    ev(0, 4'h9, 4'h0); ev(2, 4'h9, 4'h1); ev(4, 4'h9, 4'h0);
    cnt(rt_pkg::OFS_CNT_FE, 32'h0000_0001, "fe decode");
    for (int c = 0; c < 4; c++) begin
      ev(0, 4'hA, 4'h0); ev(3, 4'hA, 4'(c)); ev(3, 4'hA, 4'(c));
      ev(4, 4'hA, 4'h0);
    end
    ev(0, 4'hE, 4'h0); ev(3, 4'hE, 4'h0); ev(4, 4'hE, 4'h1);
    cnt(rt_pkg::OFS_CNT_REP, 32'h0000_0005, "rep causes");
    cnt(rt_pkg::OFS_CNT_FE, 32'h0000_0001, "fe after rep");
    cnt(rt_pkg::OFS_CNT_EX, 32'h0000_0000, "ex after rep");
    $display("test fe rep done");
  endtask
  task automatic test_untag;
    wreg(rt_pkg::OFS_UNTAG, 32'h0000_000D);
    wreg(rt_pkg::OFS_CTRL, 32'h0000_0001);
    ev(0, 4'hB, 4'h0); ev(4, 4'hB, 4'h0);
    ev(0, 4'hC, 4'h2); ev(4, 4'hC, 4'h0);
    ev(0, 4'hD, 4'h2); ev(4, 4'hD, 4'h1);
    cnt(rt_pkg::OFS_CNT_UOP, 32'h0000_0002, "uops retired");
    cnt(rt_pkg::OFS_CNT_INS, 32'h0000_0001, "instr retired");
    cnt(rt_pkg::OFS_CNT_FE, 32'h0000_0000, "fe cleared");
    wreg(rt_pkg::OFS_UNTAG, 32'h0000_0000);
    $display("test untag done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    test_regs();
    test_exec();
    test_fe_rep();
    test_untag();
    end_of_test();
  end
  // Whole run is a few hundred cycles
  initial begin
    #100000;
    n_errors++;
    $display("mismatch watchdog");
    end_of_test();
  end
endmodule
`default_nettype wire
